/* core/crcfa_consts.svh */
/*
 Constants of the CRC engine with flash auto-scan: polynomials, start values,
 widths and reset values. Definitions only; included by the package.
*/
`ifndef CRCFA_CONSTS_SVH
`define CRCFA_CONSTS_SVH

// ----------------------------------------------------------------------
// Generator polynomials and start values
// ----------------------------------------------------------------------
`define CRCFA_POLY16      16'h1021
`define CRCFA_POLY32      32'h04c11db7
`define CRCFA_INIT_ZERO   32'h00000000
`define CRCFA_INIT_ONES32 32'hffffffff
`define CRCFA_INIT_ONES16 32'h0000ffff

// ----------------------------------------------------------------------
// Widths of the flash scan
// ----------------------------------------------------------------------
`define CRCFA_FLASH_AW    14
`define CRCFA_PAGE_W      5
`define CRCFA_CNT_W       8
`define CRCFA_REM_W       17
`define CRCFA_SECT_OFS    9'h000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRCFA_RST_RESULT  32'h00000000
`define CRCFA_RST_PTR     2'h0
`define CRCFA_RST_BYTE    8'h00

`endif

/* core/crcfa_pkg.sv */
/*
 Types of the CRC engine: configuration and flash request carriers and the
 scan state. Assumes crcfa_consts.svh is on the include path.
*/
`include "crcfa_consts.svh"

package crcfa_pkg;

   // Polynomial and start value choice, levels from the control register
   typedef struct packed {
      logic poly_width_select;   // 0: 32-bit, 1: 16-bit
      logic init_value_select;   // 0: all zeros, 1: all ones
   } crcfa_cfg_s;

   // Read request towards the flash array
   typedef struct packed {
      logic                        rd;
      logic [`CRCFA_FLASH_AW-1:0]  addr;
   } crcfa_flash_req_s;

   typedef enum logic {CRCFA_IDLE, CRCFA_SCAN} crcfa_state_e;

endpackage : crcfa_pkg

/* core/crcfa_engine.sv */
/*
 CRC engine with automatic flash scan. Software feeds bytes one at a time or
 starts a scan of 512-byte sectors while the core is stalled; the result is
 reached byte by byte through a self-advancing pointer.
 Assumes: all strobes come from the core on clk, one cycle wide; the flash
 answers each read with flash_rvalid some cycles later, one answer per read.
*/
`timescale 1ns/1ps
`default_nettype none

// Guarded, so pulling the constants in here as well is harmless
`include "crcfa_consts.svh"

// Functional notes
// R1: Only two polynomials exist, 0x1021 for 16 bits and 0x04C11DB7 for 32 bits.
// R2: The width select picks the 32-bit polynomial at 0 and the 16-bit one at 1.
// R3: The start value select picks all zeros at 0 and all ones at 1.
// R4: A pulse on the initialise strobe loads the result with the chosen start value.
// R5: Software picks polynomial and start value and initialises before any data.
// R6: Every byte written to the input port is folded into the result at once.
// R7: For a scan software writes the start page and sets the auto enable bit.
// R8: Software writes the sector count before starting a scan.
// R9: Each counted sector is 512 bytes fed through the calculation.
// R10: With auto enabled any control register write starts the scan; the code starts none while the sector count is zero.
// R11: The core is held from executing until the scan completes.
// R12: Software clears the auto enable bit before reading the result.
// R13: The result is 32 bits wide in 32-bit mode and 16 bits wide in 16-bit mode.
// R14: The byte pointer selects the result byte reached by the data port and advances per access.
// R15: The result holds until initialised, overwritten or fed more input bytes.
// R16: A scan reads flash upward from the first byte of the start page like input writes.
module crcfa_engine (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          clk_en,
   input  wire crcfa_pkg::crcfa_cfg_s         cfg,
   input  wire logic                          result_init_strobe,
   input  wire logic                          in_wr,
   input  wire logic [7:0]                    crc_input_port,
   input  wire logic [`CRCFA_PAGE_W-1:0]      auto_config_reg,
   input  wire logic                          auto_flash_enable,
   input  wire logic [`CRCFA_CNT_W-1:0]       sector_count_reg,
   input  wire logic                          crc_control_reg_wr,
   input  wire logic                          ptr_wr,
   input  wire logic [1:0]                    ptr_wdata,
   input  wire logic                          dat_rd,
   input  wire logic                          dat_wr,
   input  wire logic [7:0]                    dat_wdata,
   input  wire logic                          flash_rvalid,
   input  wire logic [7:0]                    flash_rdata,
   output var  logic [7:0]                    result_rdata_q,
   output var  logic [1:0]                    result_byte_pointer_q,
   output var  logic                          core_stall_q,
   output var  crcfa_pkg::crcfa_flash_req_s   flash_req_q
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_s_n;

   // Release is synchronised so every flop leaves reset on the same edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rst_sync_q <= 2'h0;
      else        rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_s_n = rst_sync_q[1];

   // ----------------------------------------------------------------------
   // Byte-wise CRC step, MSB first, no reflection
   // ----------------------------------------------------------------------
   function automatic logic [31:0] crcfa_step(input logic [31:0] c,
                                              input logic [7:0]  b,
                                              input logic        narrow);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (narrow) begin
            fb = r[15] ^ b[i];
            r  = {16'h0000, r[14:0], 1'b0} ^ (fb ? {16'h0000, `CRCFA_POLY16} : 32'h00000000); // R1
         end else begin
            fb = r[31] ^ b[i];
            r  = {r[30:0], 1'b0} ^ (fb ? `CRCFA_POLY32 : 32'h00000000); // R1
         end
      end
      return r;
   endfunction : crcfa_step

   // Next pointer: wraps after the last byte of the active width
   function automatic logic [1:0] crcfa_ptr_next(input logic [1:0] p, input logic narrow);
      return narrow ? {1'b0, ~p[0]} : 2'(p + 2'h1);
   endfunction : crcfa_ptr_next

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   crcfa_pkg::crcfa_state_e     state_q, state_d;
   logic [31:0]                 result_q, result_d;
   logic [`CRCFA_REM_W-1:0]     remain_q, remain_d;
   logic [`CRCFA_FLASH_AW-1:0]  addr_q, addr_d;
   logic                        narrow;
   logic                        scanning;
   logic                        start;
   logic                        scan_byte;
   logic                        last_byte;
   logic                        dat_access;
   logic [31:0]                 init_val;
   logic [31:0]                 byte_mask;
   logic [31:0]                 byte_ins;
   logic [1:0]                  ptr_d;

   assign narrow   = cfg.poly_width_select;                               // R2
   assign scanning = (state_q == crcfa_pkg::CRCFA_SCAN);

   // Start value follows both selects; 16-bit mode keeps the top half clear
   assign init_val = !cfg.init_value_select ? `CRCFA_INIT_ZERO :          // R3
                     (narrow ? `CRCFA_INIT_ONES16 : `CRCFA_INIT_ONES32);   // R13

   // Any control write starts a scan while auto is on; an empty count is a no-op
   assign start     = crc_control_reg_wr && auto_flash_enable && !scanning
                      && (sector_count_reg != `CRCFA_CNT_W'(0));          // R10
   assign scan_byte = scanning && flash_rvalid;
   assign last_byte = scan_byte && (remain_q == `CRCFA_REM_W'(1));
   assign dat_access = dat_rd || dat_wr;

   // Byte lane of the data port, used for overwrite through the pointer
   assign byte_mask = 32'h000000ff << {result_byte_pointer_q, 3'h0};
   assign byte_ins  = {4{dat_wdata}} & byte_mask;

   // Result priority: initialise, flash byte, input byte, direct overwrite.
   // The core is stalled during a scan, so software sources cannot collide with it.
   always_comb begin
      result_d = result_q;                                                 // R15
      if (result_init_strobe)
         result_d = init_val;                                              // R4
      else if (scan_byte)
         result_d = crcfa_step(result_q, flash_rdata, narrow);             // R16
      else if (in_wr)
         result_d = crcfa_step(result_q, crc_input_port, narrow);          // R6
      else if (dat_wr)
         result_d = (result_q & ~byte_mask) | byte_ins;
      if (narrow)
         result_d[31:16] = 16'h0000;                                       // R13
   end

   // Scan sequencing: one read in flight, the next issued on each answer but the last
   always_comb begin
      state_d  = state_q;
      remain_d = remain_q;
      addr_d   = addr_q;
      if (start) begin
         state_d  = crcfa_pkg::CRCFA_SCAN;
         remain_d = {sector_count_reg, `CRCFA_SECT_OFS};                   // R9
         addr_d   = {auto_config_reg, `CRCFA_SECT_OFS};                    // R16
      end else if (scan_byte) begin
         remain_d = `CRCFA_REM_W'(remain_q - `CRCFA_REM_W'(1));
         addr_d   = `CRCFA_FLASH_AW'(addr_q + `CRCFA_FLASH_AW'(1));        // R16
         if (last_byte)
            state_d = crcfa_pkg::CRCFA_IDLE;
      end
   end

   // Pointer: a direct write wins over the advance of a same-cycle access
   assign ptr_d = ptr_wr ? (narrow ? {1'b0, ptr_wdata[0]} : ptr_wdata) :
                  (dat_access ? crcfa_ptr_next(result_byte_pointer_q, narrow)  // R14
                              : result_byte_pointer_q);

   // ----------------------------------------------------------------------
   // Registers, all frozen while clk_en is low
   // ----------------------------------------------------------------------
   // Result and scan bookkeeping
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         result_q <= `CRCFA_RST_RESULT;
         remain_q <= `CRCFA_REM_W'(0);
         addr_q   <= `CRCFA_FLASH_AW'(0);
         state_q  <= crcfa_pkg::CRCFA_IDLE;
      end else if (clk_en) begin
         result_q <= result_d;
         remain_q <= remain_d;
         addr_q   <= addr_d;
         state_q  <= state_d;
      end
   end

   // Stall and flash request; the stall drops with the last byte's answer
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         core_stall_q <= 1'b0;
         flash_req_q  <= '0;
      end else if (clk_en) begin
         core_stall_q     <= (state_d == crcfa_pkg::CRCFA_SCAN);           // R11
         flash_req_q.rd   <= start || (scan_byte && !last_byte);
         flash_req_q.addr <= addr_d;
      end
   end

   // Data port read answer and byte pointer
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         result_rdata_q        <= `CRCFA_RST_BYTE;
         result_byte_pointer_q <= `CRCFA_RST_PTR;
      end else if (clk_en) begin
         if (dat_rd)
            result_rdata_q <= 8'(result_q >> {result_byte_pointer_q, 3'h0}); // R14
         result_byte_pointer_q <= ptr_d;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic [`CRCFA_REM_W-1:0] run_bytes_q;
   logic [`CRCFA_REM_W-1:0] run_total_q;
   logic [`CRCFA_FLASH_AW-1:0] last_addr_q;
   logic                    seen_rd_q;

   // Helper counters of one scan, read only by the checks below
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         run_bytes_q <= `CRCFA_REM_W'(0);
         run_total_q <= `CRCFA_REM_W'(0);
         last_addr_q <= `CRCFA_FLASH_AW'(0);
         seen_rd_q   <= 1'b0;
      end else if (clk_en) begin
         if (start) begin
            run_bytes_q <= `CRCFA_REM_W'(0);
            run_total_q <= {sector_count_reg, `CRCFA_SECT_OFS};
            seen_rd_q   <= 1'b0;
         end else if (scan_byte) begin
            run_bytes_q <= `CRCFA_REM_W'(run_bytes_q + `CRCFA_REM_W'(1));
         end
         if (flash_req_q.rd) begin
            last_addr_q <= flash_req_q.addr;
            seen_rd_q   <= 1'b1;
         end
      end
   end

   sequence s_start;
      clk_en && start;
   endsequence

   sequence s_stalled_first_read;
      core_stall_q && flash_req_q.rd && flash_req_q.addr == $past(addr_d);
   endsequence

   a_init_load: assert property (@(posedge clk) disable iff (!rst_s_n) // R4
      clk_en && result_init_strobe |=> result_q == $past(init_val))
      else $error("Initialise strobe did not load the start value");

   a_start_value: assert property (@(posedge clk) disable iff (!rst_s_n) // R3
      clk_en && result_init_strobe && !cfg.init_value_select |=> result_q == 32'h00000000)
      else $error("Zero start value not loaded");

   a_narrow_width: assert property (@(posedge clk) disable iff (!rst_s_n) // R13
      clk_en && narrow |=> result_q[31:16] == 16'h0000)
      else $error("Upper half of the 16-bit result not clear");

   a_input_fold: assert property (@(posedge clk) disable iff (!rst_s_n) // R6
      clk_en && in_wr && !result_init_strobe && !scanning
      |=> result_q == crcfa_step($past(result_q), $past(crc_input_port), $past(narrow)))
      else $error("Input byte not folded into the result");

   a_poly16_known: assert property (@(posedge clk) disable iff (!rst_s_n) // R1
      clk_en && in_wr && narrow && !result_init_strobe && !scanning
      && result_q == 32'h00000000 && crc_input_port == 8'h01 |=> result_q == 32'h00001021)
      else $error("16-bit polynomial gives a wrong remainder");

   a_poly32_known: assert property (@(posedge clk) disable iff (!rst_s_n) // R2
      clk_en && in_wr && !narrow && !result_init_strobe && !scanning
      && result_q == 32'h00000000 && crc_input_port == 8'h01 |=> result_q == 32'h04c11db7)
      else $error("32-bit polynomial not chosen by a clear width select");

   a_auto_start: assert property (@(posedge clk) disable iff (!rst_s_n) // R10
      s_start |=> s_stalled_first_read)
      else $error("Control write with auto on did not start the scan");

   a_stall_hold: assert property (@(posedge clk) disable iff (!rst_s_n) // R11
      scanning && !last_byte |=> core_stall_q)
      else $error("Core released before the scan completed");

   a_flash_order: assert property (@(posedge clk) disable iff (!rst_s_n) // R16
      flash_req_q.rd && seen_rd_q && core_stall_q
      |-> flash_req_q.addr == `CRCFA_FLASH_AW'(last_addr_q + `CRCFA_FLASH_AW'(1)))
      else $error("Flash not read in ascending order");

   a_byte_total: assert property (@(posedge clk) disable iff (!rst_s_n) // R9
      $fell(core_stall_q) |-> run_bytes_q == run_total_q)
      else $error("Scan length is not 512 bytes per sector");

   a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_s_n) // R14
      clk_en && dat_access && !ptr_wr |=> result_byte_pointer_q
      == crcfa_ptr_next($past(result_byte_pointer_q), $past(narrow)))
      else $error("Byte pointer did not advance after an access");

   a_result_hold: assert property (@(posedge clk) disable iff (!rst_s_n) // R15
      !clk_en || (!result_init_strobe && !scan_byte && !in_wr && !dat_wr && !narrow)
      |=> $stable(result_q))
      else $error("Result changed with no cause");

endmodule : crcfa_engine

`default_nettype wire

/* tb/crcfa_flash_model.sv */
/*
 Behavioural flash array beside the CRC engine: answers each read with one
 valid pulse, one cycle after an even address, three after an odd one.
 Assumes one read outstanding at a time, as the engine promises.
*/
`timescale 1ns/1ps
`default_nettype none

module crcfa_flash_model (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire crcfa_pkg::crcfa_flash_req_s req,
   output var  logic                        rvalid,
   output var  logic [7:0]                  rdata,
   output var  int                          reads
);
   // ----------------------------------------------------------------------
   // Read answer
   // ----------------------------------------------------------------------
   logic [13:0] addr_q;
   logic [1:0]  wait_q;

   // Mixed latency so both prompt and slow answers are exercised; idle data
   // is the inverse of the last byte so a stale sample never looks right
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 8'h00;
         wait_q <= 2'h0;
         addr_q <= 14'h0000;
         reads  <= 0;
      end else begin
         rvalid <= 1'b0;
         if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
            if (wait_q == 2'h1) begin
               rvalid <= 1'b1;
               rdata  <= addr_q[7:0] ^ {2'h0, addr_q[13:8]} ^ 8'h5a;
            end
         end else if (rvalid) begin
            rdata <= ~rdata;
         end
         if (req.rd) begin
            addr_q <= req.addr;
            wait_q <= req.addr[0] ? 2'h3 : 2'h1;
            reads  <= reads + 1;
         end
      end
   end
endmodule : crcfa_flash_model
`default_nettype wire

/* tb/tb_crc_engine_with_flash_autoscan.sv */
/*
 Self-checking bench of the CRC engine: byte-wise feed, result port access
 and a one-sector flash scan against the flash model.
 Assumes crcfa_pkg and crcfa_flash_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_crc_engine_with_flash_autoscan;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic                         clk, rst_n, init_s, in_wr, auto_en, ctrl_wr, ce;
   logic                         ptr_wr, dat_rd, dat_wr, frv, stall;
   logic [7:0]                   in_d, dat_d, frd, rdata, cnt;
   logic [4:0]                   page;
   logic [1:0]                   ptr_d, ptr;
   crcfa_pkg::crcfa_cfg_s        cfg;
   crcfa_pkg::crcfa_flash_req_s  freq;
   int                           reads, err_total, check_count, n, cyc;
   logic [31:0]                  exp_r;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   crcfa_engine uut (.clk(clk), .rst_n(rst_n), .clk_en(ce), .cfg(cfg),
      .result_init_strobe(init_s), .in_wr(in_wr), .crc_input_port(in_d),
      .auto_config_reg(page), .auto_flash_enable(auto_en), .sector_count_reg(cnt),
      .crc_control_reg_wr(ctrl_wr), .ptr_wr(ptr_wr), .ptr_wdata(ptr_d),
      .dat_rd(dat_rd), .dat_wr(dat_wr), .dat_wdata(dat_d), .flash_rvalid(frv),
      .flash_rdata(frd), .result_rdata_q(rdata), .result_byte_pointer_q(ptr),
      .core_stall_q(stall), .flash_req_q(freq));
   crcfa_flash_model flash (.clk(clk), .rst_n(rst_n), .req(freq), .rvalid(frv),
      .rdata(frd), .reads(reads));

   // ----------------------------------------------------------------------
   // Reference, strobes and checks
   // ----------------------------------------------------------------------
   // MSB-first fold of one byte, independent of the engine's own code
   function automatic logic [31:0] step(input logic [31:0] r, input logic [7:0] b,
                                        input logic nar);
      for (int i = 7; i >= 0; i--) begin
         if (nar) r = {16'h0000, r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? 32'h1021 : 32'h0);
         else     r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? 32'h04c11db7 : 32'h0);
      end
      return r;
   endfunction : step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // One-cycle strobe; checks run one step after the taking edge
   task automatic strobe(input int k, input logic [7:0] d);
      @(posedge clk);
      case (k)
         0: init_s <= 1'b1;
         1: begin in_wr <= 1'b1; in_d <= d; end
         2: begin dat_wr <= 1'b1; dat_d <= d; end
         3: begin ptr_wr <= 1'b1; ptr_d <= d[1:0]; end
         4: dat_rd <= 1'b1;
         default: ctrl_wr <= 1'b1;
      endcase
      @(posedge clk);
      {init_s, in_wr, dat_wr, ptr_wr, dat_rd, ctrl_wr} <= 6'h00;
      #1;
   endtask : strobe
   // Reads every result byte from pointer 0 upward
   task automatic read_all();
      n = cfg.poly_width_select ? 2 : 4;
      strobe(3, 8'h00);
      for (int i = 0; i < n; i++) begin
         strobe(4, 8'h00);
         chk(rdata, exp_r[8*i +: 8], "result byte");
         chk(ptr, (i + 1) % n, "pointer advance");
      end
   endtask : read_all
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      {rst_n, init_s, in_wr, auto_en, ctrl_wr, ptr_wr, dat_rd, dat_wr} = 8'h00;
      {in_d, dat_d, cnt, page, ptr_d, cfg} = 33'h0;
      ce = 1'b1;
      err_total = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({rdata, ptr, stall, freq.rd}, 32'h0, "reset outputs");
      // Every width and start value, then three folded bytes
      for (int w = 0; w < 2; w++) begin
         for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            cfg <= '{w[0], v[0]};
            strobe(0, 8'h00);
            exp_r = v ? (w ? 32'h0000ffff : 32'hffffffff) : 32'h0;
            read_all();
            strobe(1, 8'h01);
            exp_r = step(exp_r, 8'h01, w[0]);
            strobe(1, 8'ha5);
            exp_r = step(exp_r, 8'ha5, w[0]);
            strobe(1, 8'h3c);
            exp_r = step(exp_r, 8'h3c, w[0]);
            read_all();
         end
      end
      // Overwrite one byte, idle, then the rest must be unchanged
      strobe(3, 8'h01);
      strobe(2, 8'hc3);
      exp_r[15:8] = 8'hc3;
      repeat (5) @(posedge clk);
      // A byte offered while the clock enable is low must be lost
      @(posedge clk);
      ce <= 1'b0;
      strobe(1, 8'h77);
      @(posedge clk);
      ce <= 1'b1;
      read_all();
      // Scan: count 0 and auto off start nothing, then one sector of page 3
      @(posedge clk);
      cfg <= '{1'b0, 1'b1};
      page <= 5'h03;
      auto_en <= 1'b1;
      strobe(0, 8'h00);
      strobe(5, 8'h00);
      chk(stall, 1'b0, "count zero start");
      @(posedge clk);
      auto_en <= 1'b0;
      cnt <= 8'h01;
      strobe(5, 8'h00);
      chk(stall, 1'b0, "auto off start");
      @(posedge clk);
      auto_en <= 1'b1;
      strobe(5, 8'h00);
      chk(stall, 1'b1, "stall on start");
      exp_r = 32'hffffffff;
      for (int a = 0; a < 512; a++)
         exp_r = step(exp_r, (a[7:0] ^ {2'h0, 5'h03, a[8]}) ^ 8'h5a, 1'b0);
      cyc = 0;
      // Stall is sampled a step after each edge, never in the launching step
      while (stall === 1'b1 && cyc < 4000) begin
         @(posedge clk);
         #1;
         cyc++;
      end
      if (cyc >= 4000) begin
         err_total++;
         $display("mismatch t=%0t scan never ended", $time);
      end else begin
         chk(reads, 512, "bytes per sector");
         chk(cyc > 1024, 1'b1, "stall through scan");
         @(posedge clk);
         auto_en <= 1'b0;
         read_all();
      end
      stop_test();
   end
endmodule : tb_crc_engine_with_flash_autoscan
`default_nettype wire
